// >>> core/ssdp_pkg.sv
// Shared constants and types for the scanner status and data port register bank.
package ssdp_pkg;
  // Bus widths and answers.
  localparam int AXI_ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_IMAGE = 4'h0;
  localparam logic [3:0] IDX_LEVEL = 4'h1;
  localparam logic [3:0] IDX_PINS = 4'h2;
  localparam logic [3:0] IDX_CTRL = 4'h3;
  localparam logic [3:0] IDX_ADDR_HI = 4'h4;
  localparam logic [3:0] IDX_ADDR_LO = 4'h5;
  localparam logic [3:0] IDX_DATA = 4'h6;
  localparam logic [3:0] IDX_EDGE_SEL = 4'h7;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
  localparam logic [3:0] IDX_IRQ_CLR = 4'h9;
  localparam logic [3:0] IDX_IRQ_EN = 4'ha;
  localparam logic [3:0] IDX_CONFIG = 4'hb;
  // Field positions.
  localparam int CTRL_PAUSE_BIT = 4;
  localparam int CTRL_TEST_BIT = 6;
  localparam int ADDR_DIR_BIT = 6;
  localparam int CONFIG_LARGE_BIT = 0;
  // Buffer level scaling: 2 KiB or 8 KiB per unit.
  localparam int LEVEL_SHIFT_SMALL = 11;
  localparam int LEVEL_SHIFT_LARGE = 13;
  localparam int BYTES_W = 22;
  // Table address widths.
  localparam int GAMMA_ADDR_W = 12;
  localparam int COEF_ADDR_W = 14;
  // Interrupt bit positions.
  localparam int IRQ_W = 3;
  localparam int IRQ_PAUSE = 0;
  localparam int IRQ_DATA = 1;
  localparam int IRQ_PIN = 2;
  // Values after reset.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  // Data port targets and colours.
  typedef enum logic [1:0] {
    TGT_NONE = 2'h0, TGT_OFFSET = 2'h1, TGT_GAIN = 2'h2, TGT_GAMMA = 2'h3
  } ssdp_target_t;
  localparam logic [1:0] COLOR_NONE = 2'h3;
  // Read channel states.
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001, RD_FETCH = 3'b010, RD_RESP = 3'b100
  } ssdp_rd_state_t;
endpackage : ssdp_pkg

// >>> core/ssdp_mem_if.sv
// Port bundle between the register bank and one table memory.
`timescale 1ns/100ps
interface ssdp_mem_if #(parameter int AW = 12, parameter int DW = 8) ();
  logic en;
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport client (output en, output we, output addr, output wdata, input rdata);
  modport store (input en, input we, input addr, input wdata, output rdata);
endinterface : ssdp_mem_if

// >>> core/ssdp_table_mem.sv
// Single port table memory with registered read data.
`timescale 1ns/100ps
module ssdp_table_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock.
  input wire logic clk,
  // Access port.
  ssdp_mem_if.store port
);
  logic [DW-1:0] cells [0:(1<<AW)-1];

  // Refuse shapes the port cannot carry.
  if (AW < 1 || AW > 20 || DW < 1) begin : g_bad
    $error("ssdp_table_mem: unsupported width");
  end

  // A write stores; a read loads the output register one edge later.
  always_ff @(posedge clk) begin
    if (port.en && port.we) begin
      cells[port.addr] <= port.wdata;
    end
    if (port.en && !port.we) begin
      port.rdata <= cells[port.addr];
    end
  end
endmodule : ssdp_table_mem

// >>> core/ssdp_pin_status.sv
// Paper sense and general pin status with per bit edge capture.
`timescale 1ns/100ps
module ssdp_pin_status #(
  parameter int N = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Pins and configuration.
  input wire logic [N-1:0] pins,
  input wire logic [N-1:0] edge_sel,
  input wire logic read_clear,
  // Status.
  output logic [N-1:0] status,
  output logic edge_event
);
  logic [N-1:0] pin_q;
  logic [N-1:0] sticky;
  logic [N-1:0] rise;

  if (N < 1) begin : g_bad
    $error("ssdp_pin_status: N must be positive");
  end

  // Each bit shows its level, or a sticky rising edge when edge sensitive.
  for (genvar g = 0; g < N; g++) begin : g_bit
    assign rise[g] = pins[g] & ~pin_q[g];
    assign status[g] = edge_sel[g] ? sticky[g] : pin_q[g];
    // clear on read; a new edge wins over the clear.
    always_ff @(posedge clk) begin
      if (reset) begin
        pin_q[g] <= 1'b0;
        sticky[g] <= 1'b0;
      end else begin
        pin_q[g] <= pins[g];
        sticky[g] <= (rise[g] & edge_sel[g]) | (sticky[g] & ~read_clear);
      end
    end
  end

  // Any captured edge is an interrupt event.
  assign edge_event = |(rise & edge_sel);
endmodule : ssdp_pin_status

// >>> core/ssdp_top.sv
// Image byte port, buffer level, pin status and indirect table port behind AXI4-Lite.
////////////////////////////////////////////////////////////////////////////////////
// Operation
// - Each image port read returns the next buffered image byte.
// - Level register reports buffered data in 2 KiB or 8 KiB units.
// - Pin status shows sense and general pins; read clears edge bits.
// - Control bit 4 reads one while scanning is paused on full buffer.
// - Port address is high bits 5:0 plus low byte; gamma 0 to 4095.
// - Offset and gain coefficient addresses run 0 to 16383.
// - High address bit 6 set means read, clear means write.
// - Data port access reaches current address in the selected table.
// - Registers load their defaults at reset.
// - Gamma entries move one byte, coefficient entries two bytes.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module ssdp_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register bus write channels.
  input wire logic [ssdp_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Register bus read channels.
  input wire logic [ssdp_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Image byte stream from the buffer memory.
  input wire logic [7:0] image_data,
  input wire logic image_valid,
  output logic image_ready,
  // Scanner state.
  input wire logic [ssdp_pkg::BYTES_W-1:0] buffer_bytes,
  input wire logic scan_paused,
  input wire logic media_detect_input_one,
  input wire logic media_detect_input_two,
  input wire logic [5:0] general_pin,
  // Controls and interrupt.
  output logic memory_test_mode,
  output logic irq
);
  ssdp_pkg::ssdp_rd_state_t rd_state;
  ssdp_pkg::ssdp_rd_state_t next_rd_state;
  ssdp_pkg::ssdp_target_t target;
  logic [1:0] color;
  logic [6:0] addr_hi;
  logic [7:0] addr_lo;
  logic [7:0] edge_sel;
  logic [ssdp_pkg::IRQ_W-1:0] irq_en;
  logic [ssdp_pkg::IRQ_W-1:0] irq_stat;
  logic large_mem;
  logic paused_q;
  logic [7:0] level;
  logic [7:0] coef_hold;
  logic byte_phase;
  logic aw_held;
  logic w_held;
  logic [ssdp_pkg::AXI_ADDR_W-1:0] aw_addr;
  logic [7:0] wbyte;
  logic wstrb0;
  logic [3:0] rd_idx;
  logic rd_bad;
  logic [7:0] rd_hold;
  logic rd_mem;
  logic rd_gamma;
  logic rd_phase;
  logic [7:0] pin_status;
  logic pin_event;

  ssdp_mem_if #(.AW(16), .DW(8)) gamma_bus ();
  ssdp_mem_if #(.AW(17), .DW(16)) coef_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Read and write requests are decoded from the word index.
  wire ar_taken = arvalid & arready;
  wire aw_taken = awvalid & awready;
  wire w_taken = wvalid & wready;
  wire [3:0] ar_idx = araddr[5:2];
  wire [3:0] wr_idx = aw_addr[5:2];
  wire ar_bad = (araddr[1:0] != 2'h0) || (araddr[7:6] != 2'h0) ||
    (ar_idx > ssdp_pkg::IDX_CONFIG);
  wire wr_bad = (aw_addr[1:0] != 2'h0) || (aw_addr[7:6] != 2'h0) ||
    (wr_idx > ssdp_pkg::IDX_CONFIG);
  wire do_write = aw_held & w_held & ~bvalid;
  wire wr_go = do_write & ~wr_bad & wstrb0;
  wire rd_go = ar_taken & ~ar_bad;
  wire wr_ctrl = wr_go && (wr_idx == ssdp_pkg::IDX_CTRL);
  wire wr_hi = wr_go && (wr_idx == ssdp_pkg::IDX_ADDR_HI);
  wire wr_lo = wr_go && (wr_idx == ssdp_pkg::IDX_ADDR_LO);
  wire wr_data = wr_go && (wr_idx == ssdp_pkg::IDX_DATA);
  wire wr_edge = wr_go && (wr_idx == ssdp_pkg::IDX_EDGE_SEL);
  wire wr_clr = wr_go && (wr_idx == ssdp_pkg::IDX_IRQ_CLR);
  wire wr_en = wr_go && (wr_idx == ssdp_pkg::IDX_IRQ_EN);
  wire wr_cfg = wr_go && (wr_idx == ssdp_pkg::IDX_CONFIG);
  wire rd_image = rd_go && (ar_idx == ssdp_pkg::IDX_IMAGE);
  wire rd_pins = rd_go && (ar_idx == ssdp_pkg::IDX_PINS);
  wire rd_data = rd_go && (ar_idx == ssdp_pkg::IDX_DATA);

  //////////////////////////////////////////////////////////////////////////////
  // Indirect table port.

  // port address from both address registers.
  wire [13:0] dp_addr = {addr_hi[5:0], addr_lo};
  wire dir_read = addr_hi[ssdp_pkg::ADDR_DIR_BIT];
  wire is_gamma = (target == ssdp_pkg::TGT_GAMMA) && (color != ssdp_pkg::COLOR_NONE);
  wire is_coef = ((target == ssdp_pkg::TGT_OFFSET) || (target == ssdp_pkg::TGT_GAIN)) &&
    (color != ssdp_pkg::COLOR_NONE);
  // accesses in the matching direction reach the selected table.
  wire dp_rd = rd_data & dir_read & (is_gamma | is_coef);
  wire dp_wr = wr_data & ~dir_read & (is_gamma | is_coef);
  // a coefficient is stored only when its second byte arrives.
  wire coef_we = dp_wr & is_coef & byte_phase;

  // Memory ports; gamma takes the low twelve address bits.
  assign gamma_bus.en = (dp_rd | dp_wr) & is_gamma;
  assign gamma_bus.we = dp_wr;
  assign gamma_bus.addr = {2'h0, color, dp_addr[ssdp_pkg::GAMMA_ADDR_W-1:0]};
  assign gamma_bus.wdata = wbyte;
  assign coef_bus.en = (dp_rd & is_coef) | coef_we;
  assign coef_bus.we = coef_we;
  assign coef_bus.addr = {target == ssdp_pkg::TGT_GAIN, color, dp_addr};
  assign coef_bus.wdata = {coef_hold, wbyte};

  ssdp_table_mem #(.AW(16), .DW(8)) u_gamma (
    .clk(clk),
    .port(gamma_bus)
  );

  ssdp_table_mem #(.AW(17), .DW(16)) u_coef (
    .clk(clk),
    .port(coef_bus)
  );

  // Coefficient byte order is high byte first; an address or target write restarts it.
  always_ff @(posedge clk) begin
    if (reset) begin
      byte_phase <= 1'b0;
      coef_hold <= ssdp_pkg::REG_RESET;
    end else if (wr_ctrl || wr_hi || wr_lo) begin
      byte_phase <= 1'b0;
    end else if ((dp_rd || dp_wr) && is_coef) begin
      byte_phase <= ~byte_phase;
      if (dp_wr && !byte_phase) coef_hold <= wbyte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and status registers.

  // every software register starts at its default.
  always_ff @(posedge clk) begin
    if (reset) begin
      target <= ssdp_pkg::TGT_NONE;
      color <= 2'h0;
      memory_test_mode <= 1'b0;
      addr_hi <= 7'h00;
      addr_lo <= ssdp_pkg::REG_RESET;
      edge_sel <= ssdp_pkg::REG_RESET;
      irq_en <= ssdp_pkg::IRQ_RESET;
      large_mem <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        target <= ssdp_pkg::ssdp_target_t'(wbyte[1:0]);
        color <= wbyte[3:2];
        memory_test_mode <= wbyte[ssdp_pkg::CTRL_TEST_BIT];
      end
      if (wr_hi) addr_hi <= wbyte[6:0];
      if (wr_lo) addr_lo <= wbyte;
      if (wr_edge) edge_sel <= wbyte;
      if (wr_en) irq_en <= wbyte[ssdp_pkg::IRQ_W-1:0];
      if (wr_cfg) large_mem <= wbyte[ssdp_pkg::CONFIG_LARGE_BIT];
    end
  end

  // buffered level in units of the fitted memory, saturating at 255.
  wire [ssdp_pkg::BYTES_W-1:0] lvl_units = large_mem ?
    (buffer_bytes >> ssdp_pkg::LEVEL_SHIFT_LARGE) :
    (buffer_bytes >> ssdp_pkg::LEVEL_SHIFT_SMALL);
  wire [7:0] next_level = (|lvl_units[ssdp_pkg::BYTES_W-1:8]) ? 8'hff : lvl_units[7:0];

  ssdp_pin_status #(.N(8)) u_pins (
    .clk(clk),
    .reset(reset),
    .pins({general_pin, media_detect_input_two, media_detect_input_one}),
    .edge_sel(edge_sel),
    .read_clear(rd_pins),
    .status(pin_status),
    .edge_event(pin_event)
  );

  // Events: pause entry, data arriving in an empty buffer, captured pin edge.
  wire [ssdp_pkg::IRQ_W-1:0] events = {pin_event, (level == 8'h00) && (next_level != 8'h00),
    scan_paused & ~paused_q};
  wire [ssdp_pkg::IRQ_W-1:0] clr_mask = wr_clr ? wbyte[ssdp_pkg::IRQ_W-1:0] : 3'h0;

  // Sticky status; an event in the clearing cycle survives.
  always_ff @(posedge clk) begin
    if (reset) begin
      paused_q <= 1'b0;
      level <= ssdp_pkg::REG_RESET;
      irq_stat <= ssdp_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      paused_q <= scan_paused;
      level <= next_level;
      irq_stat <= (irq_stat & ~clr_mask) | events;
      irq <= |(irq_stat & irq_en);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read view.

  logic [7:0] view [0:15];
  assign view[0] = 8'h00;
  assign view[1] = level;
  assign view[2] = pin_status;
  // pause flag follows the scanner state.
  assign view[3] = {1'b0, memory_test_mode, 1'b0, paused_q, color, target};
  assign view[4] = {1'b0, addr_hi};
  assign view[5] = addr_lo;
  assign view[6] = 8'h00;
  assign view[7] = edge_sel;
  assign view[8] = {5'h00, irq_stat};
  assign view[9] = 8'h00;
  assign view[10] = {5'h00, irq_en};
  assign view[11] = {7'h00, large_mem};
  for (genvar g = 12; g < 16; g++) begin : g_hole
    assign view[g] = 8'h00;
  end

  // Byte returned in the fetch cycle.
  wire [7:0] mem_byte = rd_gamma ? gamma_bus.rdata :
    (rd_phase ? coef_bus.rdata[7:0] : coef_bus.rdata[15:8]);
  wire [7:0] fetch_byte = (rd_idx == ssdp_pkg::IDX_IMAGE) ? (image_ready ? image_data : 8'h00) :
    (rd_mem ? mem_byte : rd_hold);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus read channel.

  // Idle takes a request, fetch waits for memory, response holds until taken.
  always_comb begin
    case (rd_state)
      ssdp_pkg::RD_IDLE: next_rd_state = ar_taken ? ssdp_pkg::RD_FETCH : ssdp_pkg::RD_IDLE;
      ssdp_pkg::RD_FETCH: next_rd_state = ssdp_pkg::RD_RESP;
      ssdp_pkg::RD_RESP: next_rd_state = rready ? ssdp_pkg::RD_IDLE : ssdp_pkg::RD_RESP;
      default: next_rd_state = ssdp_pkg::RD_IDLE;
    endcase
  end

  // Snapshot of the addressed register, taken before any read side effect.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_state <= ssdp_pkg::RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= ssdp_pkg::RESP_OKAY;
      rd_idx <= 4'h0;
      rd_bad <= 1'b0;
      rd_hold <= 8'h00;
      rd_mem <= 1'b0;
      rd_gamma <= 1'b0;
      rd_phase <= 1'b0;
      image_ready <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      arready <= (next_rd_state == ssdp_pkg::RD_IDLE);
      rvalid <= (next_rd_state == ssdp_pkg::RD_RESP);
      // pop one byte from the image stream per read.
      image_ready <= rd_image & image_valid;
      if (ar_taken) begin
        rd_idx <= ar_idx;
        rd_bad <= ar_bad;
        rd_hold <= ar_bad ? 8'h00 : view[ar_idx];
        rd_mem <= dp_rd;
        rd_gamma <= is_gamma;
        rd_phase <= byte_phase;
      end
      if (rd_state == ssdp_pkg::RD_FETCH) begin
        rdata <= {24'h00_0000, rd_bad ? 8'h00 : fetch_byte};
        rresp <= rd_bad ? ssdp_pkg::RESP_SLVERR : ssdp_pkg::RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus write channel.

  // Address and data are held in either order; the write acts when both are in.
  always_ff @(posedge clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      wbyte <= 8'h00;
      wstrb0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= ssdp_pkg::RESP_OKAY;
    end else begin
      awready <= ~aw_taken & ~aw_held & ~do_write & ~bvalid;
      wready <= ~w_taken & ~w_held & ~do_write & ~bvalid;
      if (aw_taken) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (w_taken) begin
        w_held <= 1'b1;
        wbyte <= wdata[7:0];
        wstrb0 <= wstrb[0];
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_bad ? ssdp_pkg::RESP_SLVERR : ssdp_pkg::RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_image_pop;
    rd_image && image_valid |=> image_ready ##1 (rvalid && rdata[7:0] == $past(image_data));
  endproperty
  a_image_pop: assert property (p_image_pop) else $error("image byte not returned");

  property p_level;
    !large_mem && $stable(large_mem) |=>
      level == $past((|buffer_bytes[21:19]) ? 8'hff : buffer_bytes[18:11]);
  endproperty
  a_level: assert property (p_level) else $error("buffer level wrong");

  property p_pin_clear;
    rd_pins && edge_sel[0] && $past(edge_sel[0]) && !(media_detect_input_one && !u_pins.pin_q[0])
      |=> !pin_status[0];
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("edge bit not cleared on read");

  property p_pause;
    rd_go && ar_idx == ssdp_pkg::IDX_CTRL |=> ##1 rdata[4] == $past(scan_paused, 3);
  endproperty
  a_pause: assert property (p_pause) else $error("pause flag wrong");

  property p_gamma_addr;
    gamma_bus.en |-> gamma_bus.addr[11:0] == {addr_hi[3:0], addr_lo};
  endproperty
  a_gamma_addr: assert property (p_gamma_addr) else $error("gamma address wrong");

  property p_coef_addr;
    coef_bus.en |-> coef_bus.addr[13:0] == {addr_hi[5:0], addr_lo} && is_coef;
  endproperty
  a_coef_addr: assert property (p_coef_addr) else $error("coefficient address wrong");

  property p_dir;
    (gamma_bus.we && gamma_bus.en) || coef_bus.we |-> !addr_hi[6];
  endproperty
  a_dir: assert property (p_dir) else $error("table written in read direction");

  property p_data_time;
    rd_data && dir_read && is_gamma |=> ##1 rvalid && rdata[7:0] == $past(gamma_bus.rdata);
  endproperty
  a_data_time: assert property (p_data_time) else $error("port read data wrong");

  property p_memtest;
    wr_ctrl |=> memory_test_mode == $past(wbyte[6]);
  endproperty
  a_memtest: assert property (p_memtest) else $error("test mode bit not taken");

  property p_pair;
    coef_bus.we |-> byte_phase ##1 !byte_phase;
  endproperty
  a_pair: assert property (p_pair) else $error("coefficient stored on one byte");

  c_image: cover property (rd_image && image_valid ##2 rvalid);
  c_coef: cover property (coef_bus.we);
  c_clear: cover property (rd_pins && |(pin_status & edge_sel));
endmodule : ssdp_top

// >>> test/tb_top.sv
// Self-checking bench for the scanner status and data port register bank.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [7:0] image_data = 8'h00;
  logic image_valid = 1'b0;
  logic image_ready;
  logic [ssdp_pkg::BYTES_W-1:0] buffer_bytes = 22'h0;
  logic scan_paused = 1'b0;
  logic media_detect_input_one = 1'b0;
  logic media_detect_input_two = 1'b0;
  logic [5:0] general_pin = 6'h00;
  logic memory_test_mode;
  logic irq;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] val[9];
  logic [13:0] adr[9];
  int error_cnt = 0;
  int checks_done = 0;
  int pops = 0;

  // Free running clock of 50 ns period.
  always #25 clk = ~clk;

  ssdp_top i_dut (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .image_data(image_data), .image_valid(image_valid), .image_ready(image_ready),
    .buffer_bytes(buffer_bytes), .scan_paused(scan_paused),
    .media_detect_input_one(media_detect_input_one),
    .media_detect_input_two(media_detect_input_two), .general_pin(general_pin),
    .memory_test_mode(memory_test_mode), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // Register write; the expected response is noted for the monitor.
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = ssdp_pkg::RESP_OKAY);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready === 1'b1 && !aw_ok) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wready === 1'b1 && !w_ok) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  // Register read; the expected answer is noted for the monitor.
  task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = ssdp_pkg::RESP_OKAY);
    rq.push_back({er, 24'h0, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  // Table entry k: targets offset, gain, gamma; colours red, green, blue.
  function automatic logic [1:0] tgt(input int k);
    return 2'(k / 3 + 1);
  endfunction : tgt

  // Selects target, colour, direction and address of entry k.
  task setp(input int k, input logic dir);
    wr(8'h0c, {4'h0, 2'(k % 3), tgt(k)});
    wr(8'h10, {1'b0, dir, adr[k][13:8]});
    wr(8'h14, adr[k][7:0]);
  endtask : setp

  // Monitor takes the oldest note at every answer handshake.
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready) begin
      check("read", {rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'b1 && bready) begin
      check("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    end
    // Each consumed image byte shows as one ready pulse.
    if (image_ready === 1'b1) begin
      pops++;
    end
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    int k;
    int n;
    logic [7:0] p;
    logic [13:0] m;
    n = $urandom(32'he3a8);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    for (k = 0; k < 12; k++) rd(8'(4 * k), 8'h00);
    check("irq", irq, 1'b1 ^ 1'b1);
    for (k = 0; k < 4; k++) begin
      n = $urandom_range(255, 0);
      wr(8'h2c, 8'(k[0]));
      buffer_bytes <= k[0] ? 22'(n * 8192 + $urandom_range(8191, 0))
                           : 22'(n * 2048 + $urandom_range(2047, 0));
      repeat (3) @(posedge clk);
      rd(8'h04, 8'(n));
    end
    image_valid <= 1'b1;
    for (k = 0; k < 3; k++) begin
      p = 8'($urandom);
      image_data <= p;
      rd(8'h00, p);
    end
    image_valid <= 1'b0;
    rd(8'h00, 8'h00);
    check("image pops", 34'(pops), 34'h3);
    p = 8'($urandom);
    {general_pin, media_detect_input_two, media_detect_input_one} <= p;
    repeat (3) @(posedge clk);
    rd(8'h08, p);
    rd(8'h08, p);
    {general_pin, media_detect_input_two, media_detect_input_one} <= 8'h00;
    wr(8'h1c, 8'h01);
    media_detect_input_one <= 1'b1;
    repeat (2) @(posedge clk);
    media_detect_input_one <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq masked", irq, 1'b0);
    rd(8'h08, 8'h01);
    rd(8'h08, 8'h00);
    wr(8'h28, 8'h04);
    repeat (2) @(posedge clk);
    check("irq raised", irq, 1'b1);
    wr(8'h24, 8'h04);
    repeat (2) @(posedge clk);
    check("irq cleared", irq, 1'b0);
    buffer_bytes <= 22'h3fffff;
    wr(8'h0c, 8'h40);
    check("test mode", memory_test_mode, 1'b1);
    rd(8'h04, 8'hff);
    wr(8'h24, 8'h07);
    scan_paused <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h0c, 8'h50);
    rd(8'h20, 8'h01);
    scan_paused <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h0c, 8'h40);
    wr(8'h0c, 8'h00);
    check("test mode", memory_test_mode, 1'b0);
    // table writes at edge and random addresses
    for (k = 0; k < 9; k++) begin
      // addresses kept within the target limit.
      m = (tgt(k) == ssdp_pkg::TGT_GAMMA) ? 14'h0fff : 14'h3fff;
      adr[k] = (k % 3 == 0) ? m : 14'($urandom_range(m, 0));
      val[k] = 16'($urandom);
      setp(k, 1'b0);
      if (tgt(k) != ssdp_pkg::TGT_GAMMA) wr(8'h18, val[k][15:8]);
      wr(8'h18, val[k][7:0]);
    end
    // read refused while direction is write
    rd(8'h18, 8'h00);
    for (k = 0; k < 9; k++) begin
      setp(k, 1'b1);
      if (tgt(k) != ssdp_pkg::TGT_GAMMA) rd(8'h18, val[k][15:8]);
      rd(8'h18, val[k][7:0]);
    end
    // colour code three selects no table.
    wr(8'h0c, 8'h0f);
    rd(8'h18, 8'h00);
    // a write without its low strobe stores nothing.
    wstrb <= 4'h0;
    wr(8'h14, 8'h5a);
    wstrb <= 4'hf;
    rd(8'h14, adr[8][7:0]);
    rd(8'h30, 8'h00, ssdp_pkg::RESP_SLVERR);
    rd(8'h05, 8'h00, ssdp_pkg::RESP_SLVERR);
    wr(8'h30, 8'h55, ssdp_pkg::RESP_SLVERR);
    repeat (5) @(posedge clk);
    results;
  end
endmodule : tb_top
